// file: core/csc_regs.sv
// Closed-loop speed configuration registers and their decode
// Notes on behaviour
// [RQ1] Start-up bits 2..0 pick angle pull rate, 0.01 to 2 deg/ms.
// [RQ2] Closed-loop word at 0x88, 32 bits, resets zero; bit 31 plain storage.
// [RQ3] Bit 30 set allows overmodulation; clear keeps it off.
// [RQ4] Bits 29..25 give acceleration limit, 0.5 to 70000 Hz/s, 0x1f none.
// [RQ5] Bit 24 set reuses acceleration limit for deceleration.
// [RQ6] Decel field bits 23..19 used only with guard off, bit 24 clear.
// [RQ7] Bits 18..15 pick switching rate 10 to 75 kHz; 0xe, 0xf reserved.
// [RQ8] Bit 14 clear continuous, set discontinuous vector modulation.
// [RQ9] Bit 1 set disables the speed regulator.
// [RQ10] Fields read back last written value, zero after reset.
`timescale 1ns/1ps

module csc_regs #(
    parameter int ADDR_W = 8
) (
    input  wire logic                core_clk_in,
    input  wire logic                nrst_in,
    input  wire logic [ADDR_W-1:0]   addr_in,
    input  wire logic                wr_en_in,
    input  wire logic [31:0]         wr_data_in,
    input  wire logic                rd_en_in,
    output logic [31:0]              rd_data_out,
    output logic                     rd_valid_out,
    output logic                     rd_err_out,
    output csc_pkg::csc_ctrl_s       ctrl_out
);
    import csc_pkg::*;

    if (ADDR_W < 8) begin : g_chk
        $error("ADDR_W must be at least 8");
    end

    typedef struct packed {
        logic [31:0] startup;
        logic [31:0] loop;
        logic [31:0] rd_data;
        logic        rd_valid;
        logic        rd_err;
        csc_ctrl_s   ctrl;
    } csc_state_s;

    csc_state_s st_reg;
    csc_state_s st_next;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] off);
        hit = (a == ADDR_W'(off));
    endfunction

    always_comb begin
        logic [3:0] sw;
        logic       guard;
        st_next = st_reg;
        sw      = 4'h0;
        guard   = 1'b0;
        st_next.rd_valid = 1'b0;
        st_next.rd_err   = 1'b0;
        // Full-word writes store every bit, reserved ones too
        if (wr_en_in && hit(addr_in, CSC_OFF_STARTUP_B)) begin
            st_next.startup = wr_data_in; // see RQ10
        end
        if (wr_en_in && hit(addr_in, CSC_OFF_LOOP_A)) begin
            st_next.loop = wr_data_in; // see RQ2
        end
        if (rd_en_in) begin
            st_next.rd_valid = 1'b1;
            if (hit(addr_in, CSC_OFF_STARTUP_B)) begin
                st_next.rd_data = st_reg.startup; // see RQ10
            end else if (hit(addr_in, CSC_OFF_LOOP_A)) begin
                st_next.rd_data = st_reg.loop; // see RQ10
            end else begin
                st_next.rd_data = 32'h0000_0000;
                st_next.rd_err  = 1'b1;
            end
        end
        // Decode from the new contents so settings follow a write by one edge
        st_next.ctrl.ramp_rate = csc_ramp(
            st_next.startup[CSC_RAMP_LSB +: CSC_RAMP_W]); // see RQ1
        st_next.ctrl.vector_saturation_allow =
            st_next.loop[CSC_VSAT_BIT]; // see RQ3
        st_next.ctrl.speed_rise_limit = csc_limit(
            st_next.loop[CSC_RISE_LSB +: CSC_LIM_W]); // see RQ4
        st_next.ctrl.rise_unlimited =
            st_next.loop[CSC_RISE_LSB +: CSC_LIM_W] == CSC_LIM_NONE;
        guard = st_next.loop[CSC_GUARD_BIT];
        if (st_next.loop[CSC_FSRC_BIT]) begin
            st_next.ctrl.speed_fall_limit =
                st_next.ctrl.speed_rise_limit; // see RQ5
            st_next.ctrl.fall_unlimited    = st_next.ctrl.rise_unlimited;
            st_next.ctrl.fall_limit_active = 1'b1;
        end else if (!guard) begin
            st_next.ctrl.speed_fall_limit = csc_limit(
                st_next.loop[CSC_FALL_LSB +: CSC_LIM_W]); // see RQ6
            st_next.ctrl.fall_unlimited =
                st_next.loop[CSC_FALL_LSB +: CSC_LIM_W] == CSC_LIM_NONE;
            st_next.ctrl.fall_limit_active = 1'b1;
        end else begin
            // Surge guard owns deceleration; field ignored
            st_next.ctrl.speed_fall_limit  = 18'h00000; // see RQ6
            st_next.ctrl.fall_unlimited    = 1'b0;
            st_next.ctrl.fall_limit_active = 1'b0;
        end
        sw = st_next.loop[CSC_SW_LSB +: CSC_SW_W];
        if (sw <= CSC_SW_MAX_CODE) begin
            st_next.ctrl.switching_khz = CSC_SW_BASE_KHZ
                + 7'(sw) * CSC_SW_STEP_KHZ; // see RQ7
            st_next.ctrl.switching_rate_bad = 1'b0;
        end else begin
            st_next.ctrl.switching_khz      = 7'h00;
            st_next.ctrl.switching_rate_bad = 1'b1; // see RQ7
        end
        st_next.ctrl.discontinuous_mod =
            st_next.loop[CSC_MOD_BIT]; // see RQ8
        st_next.ctrl.speed_regulator_off =
            st_next.loop[CSC_SREG_BIT]; // see RQ9
    end

    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            st_reg <= '0;
            st_reg.startup <= CSC_RST_STARTUP_B;
            st_reg.loop <= CSC_RST_LOOP_A; // see RQ2
            st_reg.ctrl.ramp_rate <= 8'h01;
            st_reg.ctrl.speed_rise_limit <= 18'h00001;
            st_reg.ctrl.speed_fall_limit <= 18'h00001;
            st_reg.ctrl.fall_limit_active <= 1'b1;
            st_reg.ctrl.switching_khz <= CSC_SW_BASE_KHZ;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rd_data_out  = st_reg.rd_data;
    assign rd_valid_out = st_reg.rd_valid;
    assign rd_err_out   = st_reg.rd_err;
    assign ctrl_out     = st_reg.ctrl;

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);

    sequence s_loop_write;
        wr_en_in && hit(addr_in, CSC_OFF_LOOP_A);
    endsequence

    a_loop_read_back: assert property ( // see RQ2
        s_loop_write ##1 (rd_en_in && hit(addr_in, CSC_OFF_LOOP_A)
            && !wr_en_in) |=> rd_data_out == $past(wr_data_in, 2))
        else $error("Loop word read back differs from write");
    a_start_read_back: assert property ( // see RQ10
        wr_en_in && hit(addr_in, CSC_OFF_STARTUP_B) ##1
        (rd_en_in && hit(addr_in, CSC_OFF_STARTUP_B) && !wr_en_in)
        |=> rd_data_out == $past(wr_data_in, 2))
        else $error("Start-up word read back differs from write");
    a_ramp_rate_map: assert property ( // see RQ1
        wr_en_in && hit(addr_in, CSC_OFF_STARTUP_B)
        && wr_data_in[2:0] == 3'h7 |=> ctrl_out.ramp_rate == 8'hc8)
        else $error("Ramp code 7 not 2 deg/ms");
    a_vsat_follows: assert property ( // see RQ3
        s_loop_write |=> ctrl_out.vector_saturation_allow
            == $past(wr_data_in[30]))
        else $error("Vector_saturation_allow wrong");
    a_rise_top_code: assert property ( // see RQ4
        s_loop_write ##0 wr_data_in[29:25] == 5'h1e
        |=> ctrl_out.speed_rise_limit == 18'h222e0
            && !ctrl_out.rise_unlimited)
        else $error("Code 0x1e not 70000 Hz/s");
    a_fall_from_rise: assert property ( // see RQ5
        st_reg.loop[24] |-> ctrl_out.fall_limit_active
            && ctrl_out.speed_fall_limit == ctrl_out.speed_rise_limit
            && ctrl_out.fall_unlimited == ctrl_out.rise_unlimited)
        else $error("Deceleration not taken from acceleration");
    a_fall_ignored: assert property ( // see RQ6
        st_reg.loop[3] && !st_reg.loop[24]
        |-> !ctrl_out.fall_limit_active)
        else $error("Deceleration field used while guard on");
    a_switch_rate: assert property ( // see RQ7
        s_loop_write ##0 wr_data_in[18:15] == 4'hd
        |=> ctrl_out.switching_khz == 7'h4b && !ctrl_out.switching_rate_bad)
        else $error("Code 0xd not 75 kHz");
    a_mod_and_loop: assert property ( // see RQ8
        s_loop_write |=> ctrl_out.discontinuous_mod == $past(wr_data_in[14])
            && ctrl_out.speed_regulator_off == $past(wr_data_in[1]))
        else $error("Modulation or regulator bit wrong"); // see RQ9
    a_rd_one_cycle: assert property (
        rd_valid_out |-> $past(rd_en_in))
        else $error("Read answer without request");

endmodule

// file: core/csc_pkg.sv
// Package for the closed-loop speed configuration register block
package csc_pkg;

    // Register byte offsets
    localparam logic [7:0]  CSC_OFF_STARTUP_B = 8'h84;
    localparam logic [7:0]  CSC_OFF_LOOP_A    = 8'h88;
    localparam logic [31:0] CSC_RST_STARTUP_B = 32'h0000_0000;
    localparam logic [31:0] CSC_RST_LOOP_A    = 32'h0000_0000;

    // Field positions, start-up settings word
    localparam int CSC_RAMP_LSB = 0;
    localparam int CSC_RAMP_W   = 3;

    // Field positions, closed-loop settings word
    localparam int CSC_RSVD_BIT  = 31;
    localparam int CSC_VSAT_BIT  = 30;
    localparam int CSC_RISE_LSB  = 25;
    localparam int CSC_LIM_W     = 5;
    localparam int CSC_FSRC_BIT  = 24;
    localparam int CSC_FALL_LSB  = 19;
    localparam int CSC_SW_LSB    = 15;
    localparam int CSC_SW_W      = 4;
    localparam int CSC_MOD_BIT   = 14;
    localparam int CSC_GUARD_BIT = 3;
    localparam int CSC_SREG_BIT  = 1;

    // Switching rate: base, step and last valid code
    localparam logic [6:0] CSC_SW_BASE_KHZ = 7'h0a;
    localparam logic [6:0] CSC_SW_STEP_KHZ = 7'h05;
    localparam logic [3:0] CSC_SW_MAX_CODE = 4'hd;
    localparam logic [4:0] CSC_LIM_NONE    = 5'h1f;

    // Decoded settings handed to the control core
    typedef struct packed {
        logic [7:0]  ramp_rate;     // Units of 0.01 deg/ms
        logic        vector_saturation_allow;
        logic [17:0] speed_rise_limit;  // Units of 0.5 Hz/s
        logic        rise_unlimited;
        logic [17:0] speed_fall_limit;  // Units of 0.5 Hz/s
        logic        fall_unlimited;
        logic        fall_limit_active;
        logic [6:0]  switching_khz;
        logic        switching_rate_bad;
        logic        discontinuous_mod;
        logic        speed_regulator_off;
    } csc_ctrl_s;

    // Ramp code to 0.01 deg/ms units
    function automatic logic [7:0] csc_ramp(input logic [2:0] code);
        case (code)
            3'h0:    csc_ramp = 8'h01;
            3'h1:    csc_ramp = 8'h05;
            3'h2:    csc_ramp = 8'h0a;
            3'h3:    csc_ramp = 8'h0f;
            3'h4:    csc_ramp = 8'h14;
            3'h5:    csc_ramp = 8'h32;
            3'h6:    csc_ramp = 8'h64;
            default: csc_ramp = 8'hc8;
        endcase
    endfunction

    // Rate limit code to 0.5 Hz/s units; last code means no limit
    function automatic logic [17:0] csc_limit(input logic [4:0] code);
        logic [17:0] t [0:31];
        t = '{18'h00001, 18'h00002, 18'h00005, 18'h0000a, 18'h0000f,
              18'h00014, 18'h00028, 18'h00050, 18'h00078, 18'h000a0,
              18'h000c8, 18'h00190, 18'h00258, 18'h00320, 18'h003e8,
              18'h004b0, 18'h00578, 18'h00640, 18'h00708, 18'h007d0,
              18'h00fa0, 18'h01f40, 18'h02ee0, 18'h03e80, 18'h04e20,
              18'h09c40, 18'h0ea60, 18'h13880, 18'h186a0, 18'h1d4c0,
              18'h222e0, 18'h3ffff};
        csc_limit = t[code];
    endfunction

endpackage

// file: dv/testbench.sv
// Self-checking testbench for the closed-loop speed settings block
`timescale 1ns/1ps
module testbench;
    import csc_pkg::*;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic        wr_en = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic        rd_en = 1'b0;
    logic [31:0] rdata;
    logic        rvalid;
    logic        rerr;
    csc_ctrl_s   ctrl;
    int          miscompares = 0;
    int          check_count = 0;
    logic [31:0] got;
    logic        err;

    csc_regs i_dut (.core_clk_in(clk), .nrst_in(nrst), .addr_in(addr),
        .wr_en_in(wr_en), .wr_data_in(wdata), .rd_en_in(rd_en),
        .rd_data_out(rdata), .rd_valid_out(rvalid), .rd_err_out(rerr),
        .ctrl_out(ctrl));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic e);
        int n;
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        n = 0;
        #1;
        while (rvalid !== 1'b1 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 8) begin
            miscompares++;
            complete_run();
        end else begin
            chk(n, 0);
            d = rdata;
            e = rerr;
        end
    endtask

    task automatic chkreg(input logic [7:0] a, input logic [31:0] exp);
        rd(a, got, err);
        chk(got, exp);
        chk(err, 1'b0);
    endtask

    // Write, then read the same word on the very next cycle
    task automatic wr_rd(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk(rvalid, 1'b1);
        chk(rdata, d);
    endtask

    // Activity flag at bit 19, deceleration limit below it
    task automatic chk_fall(input logic [31:0] exp);
        chk({ctrl.fall_limit_active, 1'b0, ctrl.speed_fall_limit},
            exp);
    endtask

    task automatic t_reset();
        chkreg(CSC_OFF_LOOP_A, 32'h0);
        chkreg(CSC_OFF_STARTUP_B, 32'h0);
        chk(ctrl.ramp_rate, 8'h01);
        chk(ctrl.speed_rise_limit, 18'h1);
        chk({ctrl.fall_limit_active, ctrl.switching_khz}, 8'h8a);
    endtask

    task automatic t_ramp();
        logic [7:0] r [8] = '{8'h01, 8'h05, 8'h0a, 8'h0f,
                              8'h14, 8'h32, 8'h64, 8'hc8};
        for (int i = 0; i < 8; i++) begin
            wr(CSC_OFF_STARTUP_B, 32'(i));
            chk(ctrl.ramp_rate, r[i]);
        end
        wr_rd(CSC_OFF_STARTUP_B, 32'hffff_fff8);
        chk(ctrl.ramp_rate, 8'h01);
        chkreg(CSC_OFF_STARTUP_B, 32'hffff_fff8);
    endtask

    task automatic t_rise();
        logic [17:0] prev = 18'h0;
        for (int c = 0; c < 31; c++) begin
            wr(CSC_OFF_LOOP_A, 32'(c) << 25);
            chk(ctrl.speed_rise_limit > prev, 1'b1);
            chk(ctrl.rise_unlimited, 1'b0);
            prev = ctrl.speed_rise_limit;
        end
        chk(prev, 32'h222e0);
        wr(CSC_OFF_LOOP_A, 32'h3e00_0000);
        chk(ctrl.rise_unlimited, 1'b1);
    endtask

    task automatic t_fall();
        wr(CSC_OFF_LOOP_A, 32'h0b10_0000);
        chk_fall(32'h8_0014);
        wr(CSC_OFF_LOOP_A, 32'h0a10_0000);
        chk_fall(32'h8_0005);
        wr(CSC_OFF_LOOP_A, 32'h0a10_0008);
        chk_fall(32'h0);
        wr(CSC_OFF_LOOP_A, 32'h0b10_0008);
        chk_fall(32'h8_0014);
        wr(CSC_OFF_LOOP_A, 32'h3ef8_0000);
        chk(ctrl.fall_unlimited, 1'b1);
        wr(CSC_OFF_LOOP_A, 32'h3f00_0000);
        chk(ctrl.fall_unlimited, 1'b1);
    endtask

    task automatic t_sw();
        for (int c = 0; c < 16; c++) begin
            wr(CSC_OFF_LOOP_A, 32'(c) << 15);
            if (c < 14) begin
                chk(ctrl.switching_khz, 32'(10 + 5 * c));
                chk(ctrl.switching_rate_bad, 1'b0);
            end else begin
                chk(ctrl.switching_khz, 32'h0);
                chk(ctrl.switching_rate_bad, 1'b1);
            end
        end
    endtask

    task automatic t_bits();
        int b [4] = '{31, 30, 14, 1};
        for (int i = 0; i < 4; i++) begin
            wr(CSC_OFF_LOOP_A, 32'h1 << b[i]);
            chkreg(CSC_OFF_LOOP_A, 32'h1 << b[i]);
            chk(ctrl.vector_saturation_allow, b[i] == 30);
            chk(ctrl.discontinuous_mod, b[i] == 14);
            chk(ctrl.speed_regulator_off, b[i] == 1);
        end
    endtask

    task automatic t_misc();
        rd(8'h40, got, err);
        chk(err, 1'b1);
        chk(got, 32'h0);
        wr(CSC_OFF_LOOP_A, 32'h1234_5678);
        wr(8'h40, 32'hffff_ffff);
        // Write and read together: read sees the old word
        @(posedge clk);
        addr  <= CSC_OFF_LOOP_A;
        wdata <= 32'h0abc_0000;
        wr_en <= 1'b1;
        rd_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
        chk(rvalid, 1'b1);
        chk(rdata, 32'h1234_5678);
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk(rvalid, 1'b1);
        chk(rdata, 32'h0abc_0000);
        chkreg(CSC_OFF_LOOP_A, 32'h0abc_0000);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        chkreg(CSC_OFF_LOOP_A, 32'h0);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_ramp();
        t_rise();
        t_fall();
        t_sw();
        t_bits();
        t_misc();
        complete_run();
    end
endmodule
